// ===== otrim_regs.sv
/*
 * Oscillator trim register block: protect key, source select, factory
 * readback and software trim setting, driving registered trim codes.
 * Assumes an Avalon-MM master holding each request until waitrequest low,
 * and factory codes held stable by the fuse logic.
 */
// What this block does
// RULE_01: Factory readback returns factory coarse code in bits 13:8, upper bits zero.
// RULE_02: Factory readback returns factory fine code in bits 3:0, bits 7:4 zero.
// RULE_03: Setting register holds writable six-bit coarse code at 13:8, resets zero.
// RULE_04: Setting register holds writable four-bit fine code at 3:0, resets zero.
// RULE_05: With enable set, the oscillator receives the software codes, not factory.
// RULE_06: Setting and enable writes are ignored unless the key holds 0xC1.
// RULE_07: Coarse code is signed 1.8 percent steps; zero means no change.
// RULE_08: Fine code is signed 0.3 percent steps; zero means no change.
// RULE_09: Eight-bit key in bits 7:0 unlocks only at 0xC1; resets zero.
// RULE_10: Enable bit 0 resets zero; clear picks factory, set picks software codes.
// RULE_11: Selected codes leave on registered outputs, one edge after any change.
`timescale 1ns/1ns
`default_nettype none

module otrim_regs (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Factory codes
    input  wire logic [5:0]  factory_coarse_code,
    input  wire logic [3:0]  factory_fine_code,
    // Oscillator trim outputs, signed step counts
    output logic      [5:0]  osc_coarse_r,
    output logic      [3:0]  osc_fine_r
);

    logic [7:0]  trim_protect_key_reg;
    logic        trim_source_select;
    logic [5:0]  set_coarse_r;
    logic [3:0]  set_fine_r;
    logic        ack_r;
    logic [31:0] rdata_nxt;
    logic        wr_go;
    logic        unlocked;

    // One wait state; a write lands on the edge that completes the transfer
    assign wr_go    = avs_write && ack_r;
    assign unlocked = (trim_protect_key_reg == otrim_pkg::UNLOCK_KEY);    // see RULE_09

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
        end
    end

    // Key register, always writable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trim_protect_key_reg <= otrim_pkg::KEY_RST;
        end else if (wr_go && avs_address == otrim_pkg::OFS_PROTECT && avs_byteenable[0]) begin
            trim_protect_key_reg <= avs_writedata[otrim_pkg::KEY_HI:0];    // see RULE_09
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trim_source_select <= 1'b0;
        end else if (wr_go && unlocked && avs_address == otrim_pkg::OFS_ENABLE
                     && avs_byteenable[0]) begin
            trim_source_select <= avs_writedata[otrim_pkg::SEL_BIT];    // see RULE_06 RULE_10
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            set_coarse_r <= otrim_pkg::COARSE_RST;
            set_fine_r   <= otrim_pkg::FINE_RST;
        end else if (wr_go && unlocked && avs_address == otrim_pkg::OFS_SETTING) begin
            if (avs_byteenable[1]) begin
                set_coarse_r <=    // see RULE_03 RULE_06
                    avs_writedata[otrim_pkg::COARSE_HI:otrim_pkg::COARSE_LO];
            end
            if (avs_byteenable[0]) begin
                set_fine_r <=    // see RULE_04 RULE_06
                    avs_writedata[otrim_pkg::FINE_HI:otrim_pkg::FINE_LO];
            end
        end
    end

    // Codes pass unchanged; the analog side weighs each step
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            osc_coarse_r <= otrim_pkg::COARSE_RST;
            osc_fine_r   <= otrim_pkg::FINE_RST;
        end else if (trim_source_select) begin
            osc_coarse_r <= set_coarse_r;    // see RULE_05 RULE_07 RULE_11
            osc_fine_r   <= set_fine_r;      // see RULE_05 RULE_08 RULE_11
        end else begin
            osc_coarse_r <= factory_coarse_code;    // see RULE_10 RULE_11
            osc_fine_r   <= factory_fine_code;
        end
    end

    otrim_regmux u_mux (
        .addr       (avs_address),
        .key        (trim_protect_key_reg),
        .sel        (trim_source_select),
        .fac_coarse (factory_coarse_code),
        .fac_fine   (factory_fine_code),
        .set_coarse (set_coarse_r),
        .set_fine   (set_fine_r),
        .rdata      (rdata_nxt)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_readdata <= otrim_pkg::WORD_ZERO;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= rdata_nxt;    // see RULE_01 RULE_02
        end
    end

    // Protection and register writes
    locked_write_a: assert property (    // see RULE_06
        @(posedge mclk) disable iff (rst)
        (wr_go && !unlocked && avs_address == otrim_pkg::OFS_SETTING)
        |=> $stable(set_coarse_r) && $stable(set_fine_r))
        else $error("setting changed while locked");

    locked_enable_a: assert property (    // see RULE_06
        @(posedge mclk) disable iff (rst)
        (wr_go && !unlocked && avs_address == otrim_pkg::OFS_ENABLE)
        |=> $stable(trim_source_select))
        else $error("enable changed while locked");

    key_store_a: assert property (    // see RULE_09
        @(posedge mclk) disable iff (rst)
        (wr_go && avs_address == otrim_pkg::OFS_PROTECT && avs_byteenable[0])
        |=> trim_protect_key_reg == $past(avs_writedata[otrim_pkg::KEY_HI:0]))
        else $error("key not stored");

    coarse_write_a: assert property (    // see RULE_03 RULE_06
        @(posedge mclk) disable iff (rst)
        (wr_go && unlocked && avs_address == otrim_pkg::OFS_SETTING && avs_byteenable[1])
        |=> set_coarse_r == $past(avs_writedata[otrim_pkg::COARSE_HI:otrim_pkg::COARSE_LO]))
        else $error("coarse setting not stored");

    fine_write_a: assert property (    // see RULE_04 RULE_06
        @(posedge mclk) disable iff (rst)
        (wr_go && unlocked && avs_address == otrim_pkg::OFS_SETTING && avs_byteenable[0])
        |=> set_fine_r == $past(avs_writedata[otrim_pkg::FINE_HI:otrim_pkg::FINE_LO]))
        else $error("fine setting not stored");

    enable_write_a: assert property (    // see RULE_06 RULE_10
        @(posedge mclk) disable iff (rst)
        (wr_go && unlocked && avs_address == otrim_pkg::OFS_ENABLE && avs_byteenable[0])
        |=> trim_source_select == $past(avs_writedata[otrim_pkg::SEL_BIT]))
        else $error("enable not stored");

    // Trim source selection
    sw_source_a: assert property (    // see RULE_05
        @(posedge mclk) disable iff (rst)
        trim_source_select && $stable(trim_source_select)
        |=> osc_coarse_r == $past(set_coarse_r) && osc_fine_r == $past(set_fine_r))
        else $error("software codes not driven");

    // Reset still seen at the release edge, so outputs load one edge later
    fac_source_a: assert property (    // see RULE_10
        @(posedge mclk) disable iff (rst)
        !rst && !trim_source_select |=> osc_coarse_r == $past(factory_coarse_code))
        else $error("factory codes not driven");

    fac_fine_src_a: assert property (    // see RULE_10
        @(posedge mclk) disable iff (rst)
        !rst && !trim_source_select |=> osc_fine_r == $past(factory_fine_code))
        else $error("factory fine code not driven");

    out_update_a: assert property (    // see RULE_11 RULE_07
        @(posedge mclk) disable iff (rst)
        $changed(set_coarse_r) && trim_source_select && $stable(trim_source_select)
        |=> osc_coarse_r == $past(set_coarse_r))
        else $error("output lags setting");

    // Read data words
    fac_read_a: assert property (    // see RULE_01
        @(posedge mclk) disable iff (rst)
        (avs_read && !ack_r && avs_address == otrim_pkg::OFS_FACTORY)
        |=> avs_readdata[otrim_pkg::COARSE_HI:otrim_pkg::COARSE_LO]
            == $past(factory_coarse_code)
            && (avs_readdata >> (otrim_pkg::COARSE_HI + 1)) == otrim_pkg::WORD_ZERO)
        else $error("factory coarse readback wrong");

    fac_fine_a: assert property (    // see RULE_02
        @(posedge mclk) disable iff (rst)
        (avs_read && !ack_r && avs_address == otrim_pkg::OFS_FACTORY)
        |=> avs_readdata[otrim_pkg::FINE_HI:otrim_pkg::FINE_LO] == $past(factory_fine_code)
            && avs_readdata[otrim_pkg::COARSE_LO-1:otrim_pkg::FINE_HI+1] == '0)
        else $error("factory fine readback wrong");

    set_read_a: assert property (    // see RULE_03 RULE_04
        @(posedge mclk) disable iff (rst)
        (avs_read && !ack_r && avs_address == otrim_pkg::OFS_SETTING)
        |=> avs_readdata[otrim_pkg::COARSE_HI:otrim_pkg::COARSE_LO] == $past(set_coarse_r)
            && avs_readdata[otrim_pkg::FINE_HI:otrim_pkg::FINE_LO] == $past(set_fine_r))
        else $error("setting readback wrong");

    key_read_a: assert property (    // see RULE_09
        @(posedge mclk) disable iff (rst)
        (avs_read && !ack_r && avs_address == otrim_pkg::OFS_PROTECT)
        |=> avs_readdata == 32'($past(trim_protect_key_reg)))
        else $error("key readback wrong");

    enable_read_a: assert property (    // see RULE_10
        @(posedge mclk) disable iff (rst)
        (avs_read && !ack_r && avs_address == otrim_pkg::OFS_ENABLE)
        |=> avs_readdata == 32'($past(trim_source_select)))
        else $error("enable readback wrong");

    // Bus handshake
    bus_answer_a: assert property (
        @(posedge mclk) disable iff (rst)
        ((avs_read || avs_write) && avs_waitrequest) |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");

    wait_pulse_a: assert property (
        @(posedge mclk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");

    readdata_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        !(avs_read && !ack_r) |=> $stable(avs_readdata))
        else $error("read data not held");

endmodule

`default_nettype wire

// ===== otrim_pkg.sv
/*
 * Package for the oscillator trim register block: offsets, field layout,
 * reset values and the unlock key.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package otrim_pkg;

    localparam int ADDR_W = 4;

    // Register byte offsets
    localparam logic [3:0] OFS_PROTECT = 4'h0;
    localparam logic [3:0] OFS_ENABLE  = 4'h4;
    localparam logic [3:0] OFS_FACTORY = 4'h8;
    localparam logic [3:0] OFS_SETTING = 4'hC;

    // Field layout
    localparam int COARSE_W  = 6;
    localparam int COARSE_LO = 8;
    localparam int COARSE_HI = 13;
    localparam int FINE_W    = 4;
    localparam int FINE_LO   = 0;
    localparam int FINE_HI   = 3;
    localparam int KEY_W     = 8;
    localparam int KEY_HI    = 7;
    localparam int SEL_BIT   = 0;

    // Values
    localparam logic [7:0]  UNLOCK_KEY  = 8'hC1;
    localparam logic [7:0]  KEY_RST     = 8'h00;
    localparam logic [5:0]  COARSE_RST  = 6'h00;
    localparam logic [3:0]  FINE_RST    = 4'h0;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

endpackage

// ===== otrim_regmux.sv
/*
 * Read-data word assembly for the trim register block.
 * Assumes the caller registers the result and supplies stable field values.
 */
`timescale 1ns/1ns
`default_nettype none

module otrim_regmux (
    // Decode
    input  wire logic [3:0]  addr,
    // Field values
    input  wire logic [7:0]  key,
    input  wire logic        sel,
    input  wire logic [5:0]  fac_coarse,
    input  wire logic [3:0]  fac_fine,
    input  wire logic [5:0]  set_coarse,
    input  wire logic [3:0]  set_fine,
    // Result
    output logic      [31:0] rdata
);

    function automatic logic [31:0] pack_trim(input logic [5:0] c, input logic [3:0] f);
        logic [31:0] w;
        w = otrim_pkg::WORD_ZERO;
        w[otrim_pkg::COARSE_HI:otrim_pkg::COARSE_LO] = c;
        w[otrim_pkg::FINE_HI:otrim_pkg::FINE_LO]     = f;
        return w;
    endfunction

    always_comb begin
        rdata = otrim_pkg::UNMAPPED_RD;
        case (addr)
            otrim_pkg::OFS_PROTECT: begin
                rdata[otrim_pkg::KEY_HI:0] = key;
            end
            otrim_pkg::OFS_ENABLE: begin
                rdata[otrim_pkg::SEL_BIT] = sel;
            end
            otrim_pkg::OFS_FACTORY: begin
                rdata = pack_trim(fac_coarse, fac_fine);    // see RULE_01 RULE_02
            end
            otrim_pkg::OFS_SETTING: begin
                rdata = pack_trim(set_coarse, set_fine);    // see RULE_03 RULE_04
            end
            default: begin
                rdata = otrim_pkg::UNMAPPED_RD;
            end
        endcase
    end

endmodule

`default_nettype wire

// ===== otrim_osc_model.sv
/*
 * Far-side model of the oscillator: supplies the factory trim codes and
 * reports the frequency shift of the applied codes in tenths of a percent.
 * Assumes the trim codes arrive as signed step counts.
 */
`timescale 1ns/1ns
`default_nettype none

module otrim_osc_model #(
    parameter logic [5:0] FAC_C = 6'h2A,
    parameter logic [3:0] FAC_F = 4'h5
) (
    // Applied trim codes
    input  wire logic [5:0]         coarse,
    input  wire logic [3:0]         fine,
    // Factory codes and resulting shift
    output logic      [5:0]         fac_coarse,
    output logic      [3:0]         fac_fine,
    output logic signed [31:0]      shift
);
    assign fac_coarse = FAC_C;
    assign fac_fine   = FAC_F;
    // 1.8 and 0.3 percent per step, zero means no change
    assign shift = 18 * $signed(coarse) + 3 * $signed(fine);
endmodule

`default_nettype wire

// ===== otrim_regs_tb_top.sv
/*
 * Bench for the trim register block: Avalon-MM transfer tasks and directed
 * sequences with expected values. Assumes the oscillator model is compiled.
 */
`timescale 1ns/1ns
`default_nettype none

module otrim_regs_tb_top;
    localparam logic [5:0]  FC  = 6'h2A;
    localparam logic [3:0]  FF  = 4'h5;
    localparam logic [31:0] FAC = 32'({FC, 4'h0, FF});
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  fac_c;
    logic [5:0]  osc_c;
    logic [3:0]  fac_f;
    logic [3:0]  osc_f;
    logic signed [31:0] shift;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          total_checks = 0;
    logic [5:0]  tc[4] = '{6'h1F, 6'h20, 6'h01, 6'h00};
    logic [3:0]  tf[4] = '{4'h7, 4'h8, 4'hF, 4'h0};
    int          ts[4] = '{579, -600, 15, 0};

    always #2 mclk = ~mclk;

    otrim_regs i_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .factory_coarse_code(fac_c),
        .factory_fine_code(fac_f), .osc_coarse_r(osc_c), .osc_fine_r(osc_f));

    otrim_osc_model #(.FAC_C(FC), .FAC_F(FF)) i_osc (.coarse(osc_c), .fine(osc_f),
        .fac_coarse(fac_c), .fac_fine(fac_f), .shift(shift));

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            print_verdict();
        end else begin
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask

    // Outputs settle one edge after the register write
    task automatic oscchk(input logic [5:0] c, input logic [3:0] f);
        repeat (2) @(posedge mclk);
        chk("osc", 32'({c, f}), 32'({osc_c, osc_f}));
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rdchk("key", 4'h0, 32'h0000_0000);
        rdchk("enable", 4'h4, 32'h0000_0000);
        rdchk("factory", 4'h8, FAC);
        rdchk("setting", 4'hC, 32'h0000_0000);
        oscchk(FC, FF);
        bus(1'b1, 4'hC, 32'h0000_3F0F);
        bus(1'b1, 4'h4, 32'h0000_0001);
        bus(1'b1, 4'h0, 32'h0000_00C0);
        bus(1'b1, 4'hC, 32'h0000_0101);
        rdchk("setting", 4'hC, 32'h0000_0000);
        rdchk("enable", 4'h4, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'h0000_00C1);
        rdchk("key", 4'h0, 32'h0000_00C1);
        avs_byteenable <= 4'h2;
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        rdchk("setting", 4'hC, 32'h0000_3F00);
        avs_byteenable <= 4'hF;
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        rdchk("setting", 4'hC, 32'h0000_3F0F);
        bus(1'b1, 4'h8, 32'hFFFF_FFFF);
        rdchk("factory", 4'h8, FAC);
        rdchk("unmapped", 4'h2, 32'h0000_0000);
        bus(1'b1, 4'h4, 32'h0000_0001);
        rdchk("enable", 4'h4, 32'h0000_0001);
        oscchk(6'h3F, 4'hF);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 4'hC, 32'({tc[i], 4'h0, tf[i]}));
            oscchk(tc[i], tf[i]);
            chk("shift", ts[i], shift);
        end
        bus(1'b1, 4'h0, 32'h0000_0000);
        bus(1'b1, 4'hC, 32'h0000_0102);
        bus(1'b1, 4'h4, 32'h0000_0000);
        rdchk("setting", 4'hC, 32'h0000_0000);
        rdchk("enable", 4'h4, 32'h0000_0001);
        oscchk(6'h00, 4'h0);
        bus(1'b1, 4'h0, 32'h0000_00C1);
        bus(1'b1, 4'h4, 32'h0000_0000);
        oscchk(FC, FF);
        bus(1'b1, 4'hC, 32'h0000_0A03);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdchk("setting", 4'hC, 32'h0000_0000);
        rdchk("key", 4'h0, 32'h0000_0000);
        oscchk(FC, FF);
        print_verdict();
    end
endmodule

`default_nettype wire
